//--- pkg/sedt_pkg.sv
// Purpose: Shared constants and types of the state and delay-by-event trigger.
// Assumes: APB register map, byte addresses, one aligned 32-bit word per register.
// Notes:   Source codes: 0..3 analog channels, 4 external input, 16..31 digital 0..15.
// Functional notes
// - State trigger fires only on chosen clock edge
// - Clock edge setting reads back as configured
// - One threshold per channel, writes replace it
// - Same threshold serves every mode using channel
// - Threshold also is violation upper threshold
// - External threshold source only on two-channel variant
// - Threshold read returns stored source level
// - Delay mode selects event count or time
// - Sequence arm, count events, then trigger
// - Arm on configured source, level, edge only
// - Each matching event edge counts once
// - Watch trigger edge after count reached
// - Trigger on configured source and edge
// - Shared source compares against one threshold
// - Event count accepts zero to sixteen million
// - AND fires on match, NAND on mismatch
// - Clock from analog, external or digital source
package sedt_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_CTRL     = 8'h00;
    localparam logic [7:0] OFF_STCLK    = 8'h04;
    localparam logic [7:0] OFF_PCARE    = 8'h08;
    localparam logic [7:0] OFF_PVAL     = 8'h0c;
    localparam logic [7:0] OFF_ARM      = 8'h10;
    localparam logic [7:0] OFF_EVT      = 8'h14;
    localparam logic [7:0] OFF_TRG      = 8'h18;
    localparam logic [7:0] OFF_CNT      = 8'h1c;
    localparam logic [7:0] OFF_THR_BASE = 8'h20;
    localparam logic [7:0] OFF_STATUS   = 8'h34;
    localparam logic [7:0] OFF_ISTAT    = 8'h38;
    localparam logic [7:0] OFF_ICLR     = 8'h3c;
    localparam logic [7:0] OFF_IEN      = 8'h40;

    // Control field positions
    localparam int unsigned CTRL_MODE_BIT  = 0;
    localparam int unsigned CTRL_KIND_BIT  = 1;
    localparam int unsigned CTRL_SLOPE_BIT = 2;
    localparam int unsigned CTRL_POL_BIT   = 3;
    localparam int unsigned CFG_SLOPE_BIT  = 8;
    localparam int unsigned STAT_STATE_LSB = 24;

    // Reset values
    localparam logic [3:0]  CTRL_RST  = 4'h4;
    localparam logic [4:0]  SRC_RST   = 5'h00;
    localparam logic        SLOPE_RST = 1'b1;
    localparam logic [31:0] PAT_RST   = 32'h0000_0000;
    localparam logic [23:0] CNT_RST   = 24'h000000;
    localparam int unsigned THR_RST   = 0;

    // Source codes and limits
    localparam logic [4:0]  SRC_EXT      = 5'h04;
    localparam logic [4:0]  SRC_DIG_BASE = 5'h10;
    localparam int unsigned THR_ENTRIES  = 5;
    localparam logic [23:0] EVT_MAX      = 24'hf42400;  // 16,000,000 edges

    // Interrupt bits
    localparam int unsigned INT_W    = 3;
    localparam int unsigned INT_TRIG = 0;
    localparam int unsigned INT_ARM  = 1;
    localparam int unsigned INT_ERR  = 2;

    // Delay-by-event sequencer phases
    typedef enum logic [1:0] {
        SEQ_ARM   = 2'b00,
        SEQ_COUNT = 2'b01,
        SEQ_TRIG  = 2'b10
    } sedt_seq_type;

endpackage : sedt_pkg

//--- core/sedt_pin_sync.sv
// Purpose: Bring asynchronous digital probe pins into the core clock domain.
// Assumes: Pins may change at any time relative to core_clk.
// Notes:   A change is accepted once the second and third stages agree.
module sedt_pin_sync #(
    parameter int unsigned W = 16
) (
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         rst,
    // Pins and clean levels
    input  wire logic [W-1:0] pinIn,
    output logic      [W-1:0] pinOut
);

    // Width check
    if (W < 1) begin : g_bad_w
        $error("sedt_pin_sync: W must be at least 1");
    end

    // One three-stage chain per pin
    for (genvar i = 0; i < W; i++) begin : g_bit
        logic meta_r;   // First stage, read only by the second
        logic s2_r;     // Second stage
        logic s3_r;     // Third stage
        logic out_r;    // Filtered level

        // Agreement filter keeps a single late-resolving sample from leaking out
        always_ff @(posedge core_clk) begin
            if (rst) begin
                meta_r <= 1'b0;
                s2_r   <= 1'b0;
                s3_r   <= 1'b0;
                out_r  <= 1'b0;
            end else begin
                meta_r <= pinIn[i];
                s2_r   <= meta_r;
                s3_r   <= s2_r;
                if (s2_r == s3_r) begin
                    out_r <= s3_r;
                end
            end
        end
        assign pinOut[i] = out_r;
    end

endmodule : sedt_pin_sync

//--- core/sedt_edge_sel.sv
// Purpose: Pick one source from the level vector and flag its chosen edge.
// Assumes: Current and previous vectors are registered one cycle apart.
// Notes:   Pure selection; every role shares the same compared levels.
module sedt_edge_sel (
    // Level history indexed by source code
    input  wire logic [31:0] curVec,
    input  wire logic [31:0] prevVec,
    // Selection
    input  wire logic [4:0]  src,
    input  wire logic        rising,
    // Result
    output logic             edgeHit
);

    logic nowLvl;   // Selected level this cycle
    logic oldLvl;   // Selected level one cycle earlier

    // Source choice
    assign nowLvl  = curVec[src];
    assign oldLvl  = prevVec[src];
    // Rising or falling transition of the chosen source
    assign edgeHit = rising ? (nowLvl & ~oldLvl) : (~nowLvl & oldLvl);

endmodule : sedt_edge_sel

//--- core/sedt_trigger_core.sv
// Purpose: State trigger and delay-by-event trigger with APB registers.
// Assumes: Analog samples arrive on core_clk; digital pins are asynchronous.
// Notes:   Time delay counts core_clk cycles instead of event edges.
module sedt_trigger_core #(
    parameter int unsigned NCH = 4,   // Analog channels, 2 or 4
    parameter int unsigned SW  = 16   // Sample and threshold width
) (
    // Clock and reset
    input  wire logic                core_clk,
    input  wire logic                rst,
    // APB slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    // Probed inputs
    input  wire logic [NCH*SW-1:0]   chanSample,
    input  wire logic [SW-1:0]       extSample,
    input  wire logic [15:0]         digIn,
    // Trigger results
    output logic                     trigOut,
    output logic                     armed,
    output logic                     irq,
    output logic [5*SW-1:0]          violationUpperThreshold
);

    // Parameter checks
    if (NCH != 2 && NCH != 4) begin : g_bad_nch
        $error("sedt_trigger_core: NCH must be 2 or 4");
    end
    if (SW < 1 || SW > 32) begin : g_bad_sw
        $error("sedt_trigger_core: SW must be 1 to 32");
    end

    localparam bit         TWO_CH  = (NCH == 2);   // External source allowed
    localparam logic [4:0] NCH_SRC = 5'(NCH);      // First code past analog range

    // Source code legality for the fitted variant
    function automatic logic srcOk(input logic [4:0] s);
        srcOk = (s < NCH_SRC) || (s == sedt_pkg::SRC_EXT && TWO_CH)
              || (s >= sedt_pkg::SRC_DIG_BASE);
    endfunction : srcOk

    // Configuration registers
    logic [3:0]             ctrl_r;         // Mode, kind, clock slope, polarity
    logic [4:0]             stClkSrc_r;     // State clock source
    logic [31:0]            patCare_r;      // Pattern care mask
    logic [31:0]            patVal_r;       // Pattern value
    logic [4:0]             armSrc_r;       // Arm source
    logic                   armRise_r;      // Arm slope
    logic [4:0]             evtSrc_r;       // Event source
    logic                   evtRise_r;      // Event slope
    logic [4:0]             trgSrc_r;       // Trigger source
    logic                   trgRise_r;      // Trigger slope
    logic [23:0]            evtTarget_r;    // Programmed event count
    logic [SW-1:0]          thresh_r [0:sedt_pkg::THR_ENTRIES-1];
    logic [sedt_pkg::INT_W-1:0] intStat_r;  // Sticky events
    logic [sedt_pkg::INT_W-1:0] intEn_r;    // Interrupt enables
    logic [31:0]            prdata_r;       // Read data register

    // Named control fields
    logic eventDelayMode;       // 1: delay trigger active
    logic delayByTime;          // 1: count cycles rather than events
    logic stClkRise;            // State clock slope
    logic statePatternPolarity; // 1: NAND
    assign eventDelayMode       = ctrl_r[sedt_pkg::CTRL_MODE_BIT];
    assign delayByTime          = ctrl_r[sedt_pkg::CTRL_KIND_BIT];
    assign stClkRise            = ctrl_r[sedt_pkg::CTRL_SLOPE_BIT];
    assign statePatternPolarity = ctrl_r[sedt_pkg::CTRL_POL_BIT];

    // APB decode
    logic       acc;        // Access phase
    logic       setupRd;    // Read setup cycle
    logic       aligned;
    logic [2:0] thrIdx;
    logic       hitCtrl, hitClk, hitCare, hitVal, hitArm, hitEvt, hitTrg, hitCnt;
    logic       hitStat, hitIstat, hitIclr, hitIen, hitThr, thrOk;
    logic       mapped, badVal, wrOk, cfgChange;
    assign acc      = psel & penable;
    assign setupRd  = psel & ~penable & ~pwrite;
    assign aligned  = (paddr[1:0] == 2'h0);
    assign thrIdx   = paddr[4:2];
    assign hitCtrl  = aligned & (paddr == sedt_pkg::OFF_CTRL);
    assign hitClk   = aligned & (paddr == sedt_pkg::OFF_STCLK);
    assign hitCare  = aligned & (paddr == sedt_pkg::OFF_PCARE);
    assign hitVal   = aligned & (paddr == sedt_pkg::OFF_PVAL);
    assign hitArm   = aligned & (paddr == sedt_pkg::OFF_ARM);
    assign hitEvt   = aligned & (paddr == sedt_pkg::OFF_EVT);
    assign hitTrg   = aligned & (paddr == sedt_pkg::OFF_TRG);
    assign hitCnt   = aligned & (paddr == sedt_pkg::OFF_CNT);
    assign hitStat  = aligned & (paddr == sedt_pkg::OFF_STATUS);
    assign hitIstat = aligned & (paddr == sedt_pkg::OFF_ISTAT);
    assign hitIclr  = aligned & (paddr == sedt_pkg::OFF_ICLR);
    assign hitIen   = aligned & (paddr == sedt_pkg::OFF_IEN);
    assign hitThr   = aligned & (paddr[7:5] == sedt_pkg::OFF_THR_BASE[7:5])
                    & (thrIdx < 3'(sedt_pkg::THR_ENTRIES));
    // Channel index inside the fitted range, external only on two channels
    assign thrOk    = hitThr & ((thrIdx < 3'(NCH)) | (thrIdx == 3'h4 & TWO_CH));
    assign mapped   = hitCtrl | hitClk | hitCare | hitVal | hitArm | hitEvt | hitTrg
                    | hitCnt | hitStat | hitIstat | hitIclr | hitIen | thrOk;
    // Illegal values are refused whole and leave the register untouched
    assign badVal   = ((hitClk | hitArm | hitEvt | hitTrg) & ~srcOk(pwdata[4:0]))
                    | (hitCnt & (pwdata > {8'h00, sedt_pkg::EVT_MAX}))
                    | hitStat | hitIstat;
    assign wrOk      = acc & pwrite & mapped & ~badVal;
    assign cfgChange = wrOk & ~(hitIclr | hitIen);
    assign pready    = acc;
    assign pslverr   = acc & (~mapped | (pwrite & badVal));

    // Control and pattern registers
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ctrl_r     <= sedt_pkg::CTRL_RST;
            stClkSrc_r <= sedt_pkg::SRC_RST;
            patCare_r  <= sedt_pkg::PAT_RST;
            patVal_r   <= sedt_pkg::PAT_RST;
            intEn_r    <= '0;
        end else begin
            if (wrOk & hitCtrl) ctrl_r     <= pwdata[3:0];
            if (wrOk & hitClk)  stClkSrc_r <= pwdata[4:0];
            if (wrOk & hitCare) patCare_r  <= pwdata;
            if (wrOk & hitVal)  patVal_r   <= pwdata;
            if (wrOk & hitIen)  intEn_r    <= pwdata[sedt_pkg::INT_W-1:0];
        end
    end

    // Delay-by-event role registers
    always_ff @(posedge core_clk) begin
        if (rst) begin
            armSrc_r    <= sedt_pkg::SRC_RST;
            armRise_r   <= sedt_pkg::SLOPE_RST;
            evtSrc_r    <= sedt_pkg::SRC_RST;
            evtRise_r   <= sedt_pkg::SLOPE_RST;
            trgSrc_r    <= sedt_pkg::SRC_RST;
            trgRise_r   <= sedt_pkg::SLOPE_RST;
            evtTarget_r <= sedt_pkg::CNT_RST;
        end else begin
            if (wrOk & hitArm) {armRise_r, armSrc_r} <= {pwdata[8], pwdata[4:0]};
            if (wrOk & hitEvt) {evtRise_r, evtSrc_r} <= {pwdata[8], pwdata[4:0]};
            if (wrOk & hitTrg) {trgRise_r, trgSrc_r} <= {pwdata[8], pwdata[4:0]};
            if (wrOk & hitCnt) evtTarget_r <= pwdata[23:0];
        end
    end

    // One threshold word per analog channel and the external input; a write simply overwrites it
    for (genvar i = 0; i < sedt_pkg::THR_ENTRIES; i++) begin : g_thr
        always_ff @(posedge core_clk) begin
            if (rst) begin
                thresh_r[i] <= SW'(sedt_pkg::THR_RST);
            end else if (wrOk & thrOk & (thrIdx == 3'(i))) begin
                thresh_r[i] <= pwdata[SW-1:0];
            end
        end
        assign violationUpperThreshold[i*SW +: SW] = thresh_r[i];
    end

    // Level vector indexed by source code
    logic [15:0] digSync;
    logic [31:0] levelNow;
    logic [31:0] curVec_r;
    logic [31:0] prevVec_r;

    sedt_pin_sync #(.W(16)) u_dig_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .pinIn    (digIn),
        .pinOut   (digSync)
    );

    // Each analog and external source is compared against its single stored level, shared by all roles
    for (genvar i = 0; i < 4; i++) begin : g_ana
        if (i < NCH) begin : g_on
            assign levelNow[i] = chanSample[i*SW +: SW] >= thresh_r[i];
        end else begin : g_off
            assign levelNow[i] = 1'b0;
        end
    end
    assign levelNow[4]     = TWO_CH & (extSample >= thresh_r[4]);
    assign levelNow[15:5]  = 11'h000;
    assign levelNow[31:16] = digSync;

    // Level history for edge detection; reset loads live levels so no false edge follows
    always_ff @(posedge core_clk) begin
        if (rst) begin
            curVec_r  <= levelNow;
            prevVec_r <= levelNow;
        end else begin
            curVec_r  <= levelNow;
            prevVec_r <= curVec_r;
        end
    end

    // Edge finders for the four roles
    logic clkEdge, armEdge, evtEdge, trgEdge;
    sedt_edge_sel u_clk_edge (.curVec(curVec_r), .prevVec(prevVec_r), .src(stClkSrc_r),
                              .rising(stClkRise), .edgeHit(clkEdge));
    sedt_edge_sel u_arm_edge (.curVec(curVec_r), .prevVec(prevVec_r), .src(armSrc_r),
                              .rising(armRise_r), .edgeHit(armEdge));
    sedt_edge_sel u_evt_edge (.curVec(curVec_r), .prevVec(prevVec_r), .src(evtSrc_r),
                              .rising(evtRise_r), .edgeHit(evtEdge));
    sedt_edge_sel u_trg_edge (.curVec(curVec_r), .prevVec(prevVec_r), .src(trgSrc_r),
                              .rising(trgRise_r), .edgeHit(trgEdge));

    // State trigger: pattern judged on the chosen clock edge only
    logic patMatch, stateFire;
    assign patMatch  = &(~(curVec_r ^ patVal_r) | ~patCare_r);
    assign stateFire = ~eventDelayMode & clkEdge & (patMatch ^ statePatternPolarity);

    // Delay-by-event sequencer
    sedt_pkg::sedt_seq_type seq_r, seq_nxt;
    logic [23:0] cnt_r, cnt_nxt, cntInc;
    logic        countTick, seqFire, armEv;
    assign cntInc    = cnt_r + 24'h000001;
    assign countTick = delayByTime | evtEdge;

    // Next phase and count; a config write restarts the hunt from arming
    always_comb begin
        seq_nxt = seq_r;
        cnt_nxt = cnt_r;
        seqFire = 1'b0;
        armEv   = 1'b0;
        if (~eventDelayMode | cfgChange) begin
            seq_nxt = sedt_pkg::SEQ_ARM;
            cnt_nxt = sedt_pkg::CNT_RST;
        end else begin
            unique case (seq_r)
                sedt_pkg::SEQ_ARM: begin
                    if (armEdge) begin
                        armEv   = 1'b1;
                        cnt_nxt = sedt_pkg::CNT_RST;
                        seq_nxt = (evtTarget_r == sedt_pkg::CNT_RST) ? sedt_pkg::SEQ_TRIG
                                                                     : sedt_pkg::SEQ_COUNT;
                    end
                end
                sedt_pkg::SEQ_COUNT: begin
                    if (countTick) begin
                        cnt_nxt = cntInc;
                        if (cntInc == evtTarget_r) seq_nxt = sedt_pkg::SEQ_TRIG;
                    end
                end
                sedt_pkg::SEQ_TRIG: begin
                    if (trgEdge) begin
                        seqFire = 1'b1;
                        seq_nxt = sedt_pkg::SEQ_ARM;
                        cnt_nxt = sedt_pkg::CNT_RST;
                    end
                end
                default: begin
                    seq_nxt = sedt_pkg::SEQ_ARM;
                end
            endcase
        end
    end

    // Sequencer registers and trigger pulse
    logic trigOut_r;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            seq_r     <= sedt_pkg::SEQ_ARM;
            cnt_r     <= sedt_pkg::CNT_RST;
            trigOut_r <= 1'b0;
        end else begin
            seq_r     <= seq_nxt;
            cnt_r     <= cnt_nxt;
            trigOut_r <= stateFire | seqFire;
        end
    end
    assign trigOut = trigOut_r;
    assign armed   = eventDelayMode & (seq_r != sedt_pkg::SEQ_ARM);

    // Sticky interrupt status; a new event beats a clear in the same cycle
    logic [sedt_pkg::INT_W-1:0] intSet, intClr;
    assign intSet[sedt_pkg::INT_TRIG] = stateFire | seqFire;
    assign intSet[sedt_pkg::INT_ARM]  = armEv;
    assign intSet[sedt_pkg::INT_ERR]  = pslverr;
    assign intClr = (wrOk & hitIclr) ? pwdata[sedt_pkg::INT_W-1:0] : '0;
    always_ff @(posedge core_clk) begin
        if (rst) intStat_r <= '0;
        else     intStat_r <= (intStat_r & ~intClr) | intSet;
    end
    assign irq = |(intStat_r & intEn_r);

    // Read mux, captured in the setup cycle so prdata comes from a flop
    logic [31:0] rdMux, thrRd;
    assign thrRd = thrOk ? 32'(thresh_r[thrIdx]) : 32'h0000_0000;
    assign rdMux = hitCtrl  ? {28'h0000000, ctrl_r} :
                   hitClk   ? {27'h0000000, stClkSrc_r} :
                   hitCare  ? patCare_r :
                   hitVal   ? patVal_r :
                   hitArm   ? {23'h000000, armRise_r, 3'h0, armSrc_r} :
                   hitEvt   ? {23'h000000, evtRise_r, 3'h0, evtSrc_r} :
                   hitTrg   ? {23'h000000, trgRise_r, 3'h0, trgSrc_r} :
                   hitCnt   ? {8'h00, evtTarget_r} :
                   hitStat  ? {6'h00, seq_r, cnt_r} :
                   hitIstat ? {29'h00000000, intStat_r} :
                   hitIen   ? {29'h00000000, intEn_r} :
                   thrRd;
    always_ff @(posedge core_clk) begin
        if (rst)          prdata_r <= 32'h0000_0000;
        else if (setupRd) prdata_r <= rdMux;
    end
    assign prdata = prdata_r;

    // Checks
    state_edge_a: assert property (@(posedge core_clk) disable iff (rst)
        trigOut_r && !$past(eventDelayMode) |-> $past(clkEdge))
        else $error("state trigger without clock edge");
    slope_read_a: assert property (@(posedge core_clk) disable iff (rst)
        setupRd && hitCtrl && !cfgChange |=> prdata_r[2] == stClkRise)
        else $error("clock slope readback wrong");
    thr_keep_a: assert property (@(posedge core_clk) disable iff (rst)
        wrOk && thrOk |=> ##1 violationUpperThreshold[SW*$past(thrIdx,2) +: SW] == $past(pwdata[SW-1:0],2))
        else $error("threshold not replaced");
    ext_reject_a: assert property (@(posedge core_clk) disable iff (rst)
        acc && hitThr && thrIdx == 3'h4 && !TWO_CH |-> pslverr)
        else $error("external threshold accepted");
    arm_cause_a: assert property (@(posedge core_clk) disable iff (rst)
        seq_r == sedt_pkg::SEQ_ARM ##1 seq_r != sedt_pkg::SEQ_ARM |-> $past(armEdge))
        else $error("armed without arm edge");
    count_done_a: assert property (@(posedge core_clk) disable iff (rst)
        seq_r == sedt_pkg::SEQ_COUNT ##1 seq_r == sedt_pkg::SEQ_TRIG |-> cnt_r == evtTarget_r)
        else $error("trigger watch before count reached");
    seq_fire_a: assert property (@(posedge core_clk) disable iff (rst)
        trigOut_r && $past(eventDelayMode) && !$past(cfgChange)
        |-> $past(seq_r) == sedt_pkg::SEQ_TRIG && $past(trgEdge))
        else $error("delay trigger out of phase");
    cnt_limit_a: assert property (@(posedge core_clk) disable iff (rst)
        evtTarget_r <= sedt_pkg::EVT_MAX)
        else $error("event count above limit");
    cnt_clear_a: assert property (@(posedge core_clk) disable iff (rst)
        cfgChange |=> cnt_r == sedt_pkg::CNT_RST && seq_r == sedt_pkg::SEQ_ARM)
        else $error("counter not cleared on config change");
    int_sticky_a: assert property (@(posedge core_clk) disable iff (rst)
        intStat_r[0] && !intClr[0] |=> intStat_r[0])
        else $error("sticky status lost");

endmodule : sedt_trigger_core

//--- tb/sedt_probe_model.sv
// Purpose: Comparator-side model feeding probed samples to the trigger core.
// Assumes: Samples change just after a rising core_clk edge, as a sampler would.
// Notes:   Channel one and all digital pins move together; the rest sit low.
module sedt_probe_model (
    // Clock
    input  wire logic        core_clk,
    // Samples toward the core
    output logic      [63:0] chanSample,
    output logic      [15:0] extSample,
    output logic      [15:0] digIn
);
    timeunit 1ns;
    timeprecision 100ps;

    // Quiet start: every source below any nonzero level
    initial begin
        chanSample = 64'h0;
        extSample  = 16'h0;
        digIn      = 16'h0;
    end

    // Full or empty swing on channel one, then room for the edge to pass through
    task automatic drive(input logic hi);
        @(posedge core_clk);
        chanSample[15:0] <= hi ? 16'hffff : 16'h0000;
        digIn            <= {16{hi}};
        repeat (8) @(posedge core_clk);
    endtask : drive
endmodule : sedt_probe_model

//--- tb/state_and_event_delay_trigger_tb_top.sv
// Purpose: Self-checking bench of the state and delay-by-event trigger core.
// Assumes: Four channels, 16-bit samples, zero-wait APB slave.
// Notes:   Expectations come from integer tables, never from the design.
module state_and_event_delay_trigger_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic        core_clk = 1'b0;  // 200 MHz core clock
    logic        rst, psel, penable, pwrite, pready, pslverr, trigOut, armed, irq, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [63:0] chanSample;
    logic [15:0] extSample, digIn;
    logic [79:0] violUpper;
    int          n_fail = 0, tests_run = 0, trigCnt = 0, seed, c, i, k;
    int          thr[4];  // Model of stored levels
    logic [3:0]  ctrlTab[3] = '{4'h4, 4'h0, 4'h8};  // Rising, falling, inverted

    always #2.5 core_clk = ~core_clk;
    // Count pulses; nonblocking so readers at an edge see a settled value
    always @(posedge core_clk) if (trigOut === 1'b1) trigCnt <= trigCnt + 1;

    sedt_trigger_core #(.NCH(4), .SW(16)) dut_u (
        .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .chanSample(chanSample), .extSample(extSample), .digIn(digIn), .trigOut(trigOut),
        .armed(armed), .irq(irq), .violationUpperThreshold(violUpper));
    sedt_probe_model probe_u (.core_clk(core_clk), .chanSample(chanSample),
        .extSample(extSample), .digIn(digIn));

    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer; request held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int j;
        @(posedge core_clk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        for (j = 0; j < 50; j++) begin
            @(posedge core_clk);
            if (pready === 1'b1) break;
        end
        if (j == 50) begin
            n_fail++;
            finish_test();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Write and compare the error answer
    task automatic wchk(input logic [7:0] a, input logic [31:0] d, input logic e);
        apb(1'b1, a, d);
        chk({31'h0, err}, {31'h0, e});
    endtask : wchk

    initial begin
        seed = 32'h2cba2cfd;
        {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        apb(1'b0, sedt_pkg::OFF_CTRL, 32'h0);
        chk(rd, 32'h4);
        // Two rounds of random levels: the second must replace the first
        for (k = 0; k < 2; k++) begin
            for (i = 0; i < 4; i++) begin
                thr[i] = 32'h100 + ($random(seed) & 32'h3fff);
                wchk(sedt_pkg::OFF_THR_BASE + 8'(4 * i), thr[i], 1'b0);
            end
        end
        for (i = 0; i < 4; i++) begin
            apb(1'b0, sedt_pkg::OFF_THR_BASE + 8'(4 * i), 32'h0);
            chk(rd, thr[i]);
            chk({16'h0, violUpper[i*16+:16]}, thr[i]);
        end
        wchk(8'h30, 32'h5, 1'b1);
        wchk(sedt_pkg::OFF_ARM, 32'h105, 1'b1);
        wchk(sedt_pkg::OFF_CNT, 32'hf42401, 1'b1);
        wchk(sedt_pkg::OFF_CNT, 32'hf42400, 1'b0);
        wchk(8'h80, 32'h0, 1'b1);
        $display("done: registers");
        // State trigger: pulse count per rise and per fall of the clock source
        for (k = 0; k < 3; k++) begin
            wchk(sedt_pkg::OFF_CTRL, {28'h0, ctrlTab[k]}, 1'b0);
            c = trigCnt;
            probe_u.drive(1'b1);
            chk(trigCnt - c, ctrlTab[k] == 4'h4);
            c = trigCnt;
            probe_u.drive(1'b0);
            chk(trigCnt - c, ctrlTab[k] == 4'h0);
        end
        chk({31'h0, irq}, 32'h0);
        // Clock from digital pin 0 through the pin synchroniser
        wchk(sedt_pkg::OFF_STCLK, 32'h10, 1'b0);
        wchk(sedt_pkg::OFF_CTRL, 32'h4, 1'b0);
        c = trigCnt;
        probe_u.drive(1'b1);
        chk(trigCnt - c, 32'h1);
        c = trigCnt;
        probe_u.drive(1'b0);
        chk(trigCnt - c, 32'h0);
        $display("done: state trigger");
        // Delay by two events, all roles on channel one
        wchk(sedt_pkg::OFF_CNT, 32'h2, 1'b0);
        wchk(sedt_pkg::OFF_ICLR, 32'h7, 1'b0);
        wchk(sedt_pkg::OFF_IEN, 32'h1, 1'b0);
        chk({31'h0, irq}, 32'h0);
        wchk(sedt_pkg::OFF_CTRL, 32'h5, 1'b0);
        for (k = 0; k < 4; k++) begin
            c = trigCnt;
            probe_u.drive(1'b1);
            probe_u.drive(1'b0);
            chk(trigCnt - c, k == 3);
            chk({31'h0, armed}, k < 3);
        end
        chk({31'h0, irq}, 32'h1);
        wchk(sedt_pkg::OFF_ICLR, 32'h1, 1'b0);
        @(posedge core_clk);
        chk({31'h0, irq}, 32'h0);
        // Delay by time: count runs out on cycles, so the second rise fires
        wchk(sedt_pkg::OFF_CTRL, 32'h7, 1'b0);
        c = trigCnt;
        probe_u.drive(1'b1);
        probe_u.drive(1'b0);
        probe_u.drive(1'b1);
        chk(trigCnt - c, 32'h1);
        $display("done: delay by event");
        finish_test();
    end
endmodule : state_and_event_delay_trigger_tb_top
